// >>> hdl/frt_cap_if.sv
`timescale 1ns/1ns
interface frt_cap_if;
   logic sel_rise;
   logic sel_fall;
   logic evt;
   modport core (output sel_rise, output sel_fall, input evt);
   modport chan (input sel_rise, input sel_fall, output evt);
endinterface : frt_cap_if

// >>> hdl/frt_capture.sv
`timescale 1ns/1ns
`include "frt_regs.svh"
module frt_capture
   import frt_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic pin,
   frt_cap_if.chan ch
);

   frt_cap_s s_reg;
   frt_cap_s s_next;
   logic rise;
   logic fall;

   assign rise = s_reg.sync2 & ~s_reg.prev;
   assign fall = ~s_reg.sync2 & s_reg.prev;

   always_comb begin
      s_next = s_reg;
      s_next.sync1 = pin;
      s_next.sync2 = s_reg.sync1;
      s_next.prev = s_reg.sync2;
      if (s_reg.warm != `FRT_SYNC_WARM) begin
         s_next.warm = 2'(s_reg.warm + 2'h1);
      end
      // ignore the edge that the reset value of the chain would fake
      s_next.evt = (s_reg.warm == `FRT_SYNC_WARM) &&
                   ((rise && ch.sel_rise) || (fall && ch.sel_fall));
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign ch.evt = s_reg.evt;

   a_edge_select: assert property (@(posedge clock) disable iff (!rst_b)
      (s_reg.warm == `FRT_SYNC_WARM && rise && ch.sel_rise) |=> s_reg.evt)
      else $error("selected rising edge lost");
   a_edge_reject: assert property (@(posedge clock) disable iff (!rst_b)
      (fall && !ch.sel_fall) |=> !s_reg.evt)
      else $error("unselected falling edge taken");

endmodule : frt_capture

// >>> hdl/frt_pkg.sv
package frt_pkg;

   typedef logic [15:0] frt_word_t;

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic evt;
      logic [1:0] warm;
   } frt_cap_s;

   typedef struct packed {
      frt_word_t count;
      frt_word_t cmp_a;
      frt_word_t cmp_b;
      frt_word_t cap_a;
      frt_word_t cap_b;
      frt_word_t cap_c;
      frt_word_t cap_d;
      logic [7:1] flags;
      logic clr_a;
      logic [7:1] ien;
      logic [3:0] edge_sel;
      logic buf_a;
      logic buf_b;
      logic [7:1] armed;
      logic [7:0] rdata;
      logic [7:1] sticky;
      logic [7:1] mask;
      logic [7:1] irq;
      logic irq_any;
   } frt_core_s;

endpackage : frt_pkg

// >>> hdl/frt_regs.svh
`ifndef FRT_REGS_SVH
`define FRT_REGS_SVH

// byte addresses on the 8-bit register port
`define FRT_OFS_ENABLES 16'hFF90
`define FRT_OFS_STATUS 16'hFF91
`define FRT_OFS_COUNT_HI 16'hFF92
`define FRT_OFS_COUNT_LO 16'hFF93
`define FRT_OFS_CONTROL 16'hFF96
`define FRT_OFS_CAP_A_HI 16'hFF98
`define FRT_OFS_CAP_A_LO 16'hFF99
`define FRT_OFS_CAP_B_HI 16'hFF9A
`define FRT_OFS_CAP_B_LO 16'hFF9B
`define FRT_OFS_CAP_C_HI 16'hFF9C
`define FRT_OFS_CAP_C_LO 16'hFF9D
`define FRT_OFS_CAP_D_HI 16'hFF9E
`define FRT_OFS_CAP_D_LO 16'hFF9F
`define FRT_OFS_EVENTS 16'hFFA0
`define FRT_OFS_EVMASK 16'hFFA1
`define FRT_OFS_CMP_A_HI 16'hFFA2
`define FRT_OFS_CMP_A_LO 16'hFFA3
`define FRT_OFS_CMP_B_HI 16'hFFA4
`define FRT_OFS_CMP_B_LO 16'hFFA5

// flag and enable bit positions (shared layout)
`define FRT_BIT_CAP_A 7
`define FRT_BIT_CAP_B 6
`define FRT_BIT_CAP_C 5
`define FRT_BIT_CAP_D 4
`define FRT_BIT_CMP_A 3
`define FRT_BIT_CMP_B 2
`define FRT_BIT_WRAP 1
`define FRT_BIT_CLR_A 0
`define FRT_BIT_IEN_FIXED 0

// control register fields
`define FRT_BIT_EDGE_A 7
`define FRT_BIT_EDGE_D 4
`define FRT_BIT_BUF_A 3
`define FRT_BIT_BUF_B 2

// reset values and the counter maximum
`define FRT_RST_STATUS 8'h00
`define FRT_RST_ENABLES 8'h01
`define FRT_RST_COUNT 16'h0000
`define FRT_RST_CMP 16'hFFFF
`define FRT_RST_CAP 16'h0000
`define FRT_COUNT_MAX 16'hFFFF

// synchroniser settle count before edges are trusted
`define FRT_SYNC_WARM 2'h3

`endif

// >>> hdl/frt_top.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`include "frt_regs.svh"
module frt_top
   import frt_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic standby,
   input wire logic cap_in_a,
   input wire logic cap_in_b,
   input wire logic cap_in_c,
   input wire logic cap_in_d,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic cap_a_irq,
   output logic cap_b_irq,
   output logic cap_c_irq,
   output logic cap_d_irq,
   output logic cmp_a_irq,
   output logic cmp_b_irq,
   output logic wrap_irq,
   output logic irq
);

   frt_core_s s_reg;
   frt_core_s s_next;
   logic [3:0] pins;
   logic [3:0] rise_sel;
   logic [3:0] fall_sel;
   logic [3:0] evt;
   logic match_a;
   logic match_b;
   logic clear_hit;
   logic wrap;
   logic [7:1] set_vec;
   logic edge_a;
   logic edge_b;
   logic edge_c;
   logic edge_d;

   function automatic frt_core_s reset_state();
      frt_core_s r;
      logic [7:0] st;
      logic [7:0] en;
      st = `FRT_RST_STATUS;
      en = `FRT_RST_ENABLES;
      r = '0;
      r.count = `FRT_RST_COUNT;
      r.cmp_a = `FRT_RST_CMP;
      r.cmp_b = `FRT_RST_CMP;
      r.cap_a = `FRT_RST_CAP;
      r.cap_b = `FRT_RST_CAP;
      r.cap_c = `FRT_RST_CAP;
      r.cap_d = `FRT_RST_CAP;
      r.flags = st[7:1];
      r.clr_a = st[`FRT_BIT_CLR_A];
      r.ien = en[7:1];
      return r;
   endfunction : reset_state

   function automatic frt_word_t put_byte(frt_word_t w, logic hi,
                                          logic [7:0] b);
      frt_word_t r;
      r = w;
      if (hi) begin
         r[15:8] = b;
      end else begin
         r[7:0] = b;
      end
      return r;
   endfunction : put_byte

   // edge selection, index 3 is channel A down to 0 for channel D
   assign pins = {cap_in_a, cap_in_b, cap_in_c, cap_in_d};
   assign edge_a = s_reg.edge_sel[3];
   assign edge_b = s_reg.edge_sel[2];
   assign edge_c = s_reg.edge_sel[1];
   assign edge_d = s_reg.edge_sel[0];
   // buffered pair with unequal edge bits captures on both edges
   assign rise_sel[3] = edge_a | (s_reg.buf_a & edge_c);
   assign fall_sel[3] = ~edge_a | (s_reg.buf_a & ~edge_c);
   assign rise_sel[2] = edge_b | (s_reg.buf_b & edge_d);
   assign fall_sel[2] = ~edge_b | (s_reg.buf_b & ~edge_d);
   assign rise_sel[1] = edge_c;
   assign fall_sel[1] = ~edge_c;
   assign rise_sel[0] = edge_d;
   assign fall_sel[0] = ~edge_d;

   frt_cap_if cap_if [4] ();

   for (genvar i = 0; i < 4; i++) begin : g_chan
      assign cap_if[i].sel_rise = rise_sel[i];
      assign cap_if[i].sel_fall = fall_sel[i];
      assign evt[i] = cap_if[i].evt;
      frt_capture u_cap (
         .clock(clock),
         .rst_b(rst_b),
         .pin(pins[i]),
         .ch(cap_if[i])
      );
   end

   assign match_a = s_reg.count == s_reg.cmp_a;
   assign match_b = s_reg.count == s_reg.cmp_b;
   assign clear_hit = match_a && s_reg.clr_a;
   assign wrap = (s_reg.count == `FRT_COUNT_MAX) && !clear_hit;
   assign set_vec = {evt, match_a, match_b, wrap};

   always_comb begin
      logic [7:1] clr_vec;
      logic [7:1] rd_clr;
      clr_vec = '0;
      rd_clr = '0;
      s_next = s_reg;
      s_next.rdata = '0;

      if (clear_hit) begin
         s_next.count = `FRT_RST_COUNT;
      end else begin
         s_next.count = s_reg.count + 16'h0001;
      end

      if (evt[3]) begin
         if (s_reg.buf_a) begin
            s_next.cap_c = s_reg.cap_a;
         end
         s_next.cap_a = s_reg.count;
      end
      if (evt[2]) begin
         if (s_reg.buf_b) begin
            s_next.cap_d = s_reg.cap_b;
         end
         s_next.cap_b = s_reg.count;
      end
      if (evt[1] && !s_reg.buf_a) begin
         s_next.cap_c = s_reg.count;
      end
      if (evt[0] && !s_reg.buf_b) begin
         s_next.cap_d = s_reg.count;
      end

      if (rd) begin
         case (addr)
            `FRT_OFS_ENABLES: s_next.rdata = {s_reg.ien, 1'b1};
            `FRT_OFS_STATUS: begin
               s_next.rdata = {s_reg.flags, s_reg.clr_a};
               s_next.armed = s_reg.armed | s_reg.flags;
            end
            `FRT_OFS_COUNT_HI: s_next.rdata = s_reg.count[15:8];
            `FRT_OFS_COUNT_LO: s_next.rdata = s_reg.count[7:0];
            `FRT_OFS_CONTROL: s_next.rdata = {s_reg.edge_sel, s_reg.buf_a,
                                              s_reg.buf_b, 2'b00};
            `FRT_OFS_CAP_A_HI: s_next.rdata = s_reg.cap_a[15:8];
            `FRT_OFS_CAP_A_LO: s_next.rdata = s_reg.cap_a[7:0];
            `FRT_OFS_CAP_B_HI: s_next.rdata = s_reg.cap_b[15:8];
            `FRT_OFS_CAP_B_LO: s_next.rdata = s_reg.cap_b[7:0];
            `FRT_OFS_CAP_C_HI: s_next.rdata = s_reg.cap_c[15:8];
            `FRT_OFS_CAP_C_LO: s_next.rdata = s_reg.cap_c[7:0];
            `FRT_OFS_CAP_D_HI: s_next.rdata = s_reg.cap_d[15:8];
            `FRT_OFS_CAP_D_LO: s_next.rdata = s_reg.cap_d[7:0];
            `FRT_OFS_EVENTS: begin
               s_next.rdata = {s_reg.sticky, 1'b0};
               rd_clr = s_reg.sticky;
            end
            `FRT_OFS_EVMASK: s_next.rdata = {s_reg.mask, 1'b0};
            `FRT_OFS_CMP_A_HI: s_next.rdata = s_reg.cmp_a[15:8];
            `FRT_OFS_CMP_A_LO: s_next.rdata = s_reg.cmp_a[7:0];
            `FRT_OFS_CMP_B_HI: s_next.rdata = s_reg.cmp_b[15:8];
            `FRT_OFS_CMP_B_LO: s_next.rdata = s_reg.cmp_b[7:0];
            default: s_next.rdata = '0;
         endcase
      end

      if (wr) begin
         case (addr)
            `FRT_OFS_ENABLES: s_next.ien = wdata[7:1];
            `FRT_OFS_STATUS: begin
               // only zeros written over previously read ones clear
               clr_vec = s_reg.armed & ~wdata[7:1];
               s_next.clr_a = wdata[`FRT_BIT_CLR_A];
            end
            `FRT_OFS_CONTROL: begin
               s_next.edge_sel = wdata[`FRT_BIT_EDGE_A:`FRT_BIT_EDGE_D];
               s_next.buf_a = wdata[`FRT_BIT_BUF_A];
               s_next.buf_b = wdata[`FRT_BIT_BUF_B];
            end
            `FRT_OFS_EVMASK: s_next.mask = wdata[7:1];
            `FRT_OFS_CMP_A_HI: s_next.cmp_a = put_byte(s_reg.cmp_a, 1'b1,
                                                       wdata);
            `FRT_OFS_CMP_A_LO: s_next.cmp_a = put_byte(s_reg.cmp_a, 1'b0,
                                                       wdata);
            `FRT_OFS_CMP_B_HI: s_next.cmp_b = put_byte(s_reg.cmp_b, 1'b1,
                                                       wdata);
            `FRT_OFS_CMP_B_LO: s_next.cmp_b = put_byte(s_reg.cmp_b, 1'b0,
                                                       wdata);
            default: clr_vec = '0;
         endcase
      end

      // set beats a clear landing in the same cycle
      s_next.flags = (s_reg.flags & ~clr_vec) | set_vec;
      // arming lasts until the clearing write
      s_next.armed = s_next.armed & ~clr_vec;
      s_next.sticky = (s_reg.sticky & ~rd_clr) | set_vec;

      if (standby) begin
         s_next = reset_state();
      end

      s_next.irq = s_next.flags & s_next.ien;
      s_next.irq_any = |(s_next.sticky & s_next.mask);
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= reset_state();
      end else begin
         s_reg <= s_next;
      end
   end

   assign rdata = s_reg.rdata;
   assign cap_a_irq = s_reg.irq[`FRT_BIT_CAP_A];
   assign cap_b_irq = s_reg.irq[`FRT_BIT_CAP_B];
   assign cap_c_irq = s_reg.irq[`FRT_BIT_CAP_C];
   assign cap_d_irq = s_reg.irq[`FRT_BIT_CAP_D];
   assign cmp_a_irq = s_reg.irq[`FRT_BIT_CMP_A];
   assign cmp_b_irq = s_reg.irq[`FRT_BIT_CMP_B];
   assign wrap_irq = s_reg.irq[`FRT_BIT_WRAP];
   assign irq = s_reg.irq_any;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   a_cap_irq_gate: assert property (
      cap_a_irq |-> s_reg.flags[7] && s_reg.ien[7])
      else $error("capture irq without flag and enable");
   a_cmp_irq_gate: assert property (
      $rose(cmp_b_irq) |-> $past(match_b || s_reg.flags[2])
                           && s_reg.ien[2])
      else $error("compare irq without cause");
   a_wrap_irq_gate: assert property (
      (wrap && s_reg.ien[1] && !standby &&
       !(wr && addr == `FRT_OFS_ENABLES)) |=> wrap_irq)
      else $error("wrap irq missing after wrap");
   a_ien_fixed_bit: assert property (
      (rd && addr == `FRT_OFS_ENABLES && !standby) |=> rdata[0])
      else $error("enable bit 0 not read as one");
   a_no_sw_set: assert property (
      (wr && addr == `FRT_OFS_STATUS && set_vec == '0 && !standby)
      |=> (s_reg.flags & ~$past(s_reg.flags)) == '0)
      else $error("software set a status flag");
   a_clear_needs_read: assert property (
      $fell(s_reg.flags[7]) |-> $past(standby) ||
         $past(wr && addr == `FRT_OFS_STATUS && !wdata[7]
               && s_reg.armed[7]))
      else $error("flag cleared without read then write");
   a_capture_plain: assert property (
      (evt[3] && !s_reg.buf_a && !standby) |=>
         s_reg.cap_a == $past(s_reg.count))
      else $error("capture A did not take count");
   a_buffer_shift_b: assert property (
      (evt[2] && s_reg.buf_b && !standby) |=>
         s_reg.cap_d == $past(s_reg.cap_b))
      else $error("buffered B did not shift into D");
   a_c_blocked: assert property (
      (evt[1] && s_reg.buf_a && !evt[3] && !standby) |=>
         $stable(s_reg.cap_c) && s_reg.flags[5])
      else $error("input C captured while A buffered");
   a_d_capture: assert property (
      (evt[0] && !s_reg.buf_b && !standby) |=>
         s_reg.cap_d == $past(s_reg.count) && s_reg.flags[4])
      else $error("input D capture or flag missing");
   a_match_flag: assert property (
      (match_a && !standby) |=> s_reg.flags[3] ##1 s_reg.flags[3] ||
         $past(wr && addr == `FRT_OFS_STATUS) || $past(standby))
      else $error("compare flag A not set");
   a_clear_on_match: assert property (
      (clear_hit && !standby) |=> s_reg.count == `FRT_RST_COUNT
         ##1 s_reg.count == 16'h0001 || $past(clear_hit) || $past(standby))
      else $error("counter not cleared on match A");
   a_wrap_flag: assert property (
      (wrap && !standby) |=> s_reg.flags[1] && s_reg.count == 16'h0000)
      else $error("wrap flag not set on rollover");
   a_standby_init: assert property (
      standby |=> s_reg.flags == '0 && !s_reg.clr_a && s_reg.ien == '0)
      else $error("standby did not reinitialise");
   a_irq_drop: assert property (
      (cap_b_irq && wr && addr == `FRT_OFS_ENABLES && !wdata[6])
      |=> !cap_b_irq)
      else $error("irq not dropped after enable clear");

endmodule : frt_top

// >>> verif/frt_pin_model.sv
`timescale 1ns/1ns
module frt_pin_model (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [3:0] want,
   output logic [3:0] pins
);
   logic [1:0] hold_reg [4];
   // each level stands at least three cycles, so edges stay far apart
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pins <= 4'h0;
         for (int i = 0; i < 4; i++) hold_reg[i] <= 2'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (hold_reg[i] != 2'h0) begin
               hold_reg[i] <= hold_reg[i] - 2'h1;
            end else if (pins[i] != want[i]) begin
               pins[i] <= want[i];
               hold_reg[i] <= 2'h2;
            end
         end
      end
   end
endmodule : frt_pin_model

// >>> verif/tb_top.sv
`timescale 1ns/1ns
`include "frt_regs.svh"
module tb_top;
   import frt_pkg::*;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic standby = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic [3:0] want = 4'h0;
   logic [3:0] pins;
   logic [6:0] irqs;
   logic irq;
   int miscompares = 0;
   int checks = 0;
   int seed = 78665;
   logic [15:0] d;
   logic [15:0] v;
   logic [15:0] old;
   logic [7:0] e;

   always #20 clock = ~clock;

   frt_pin_model pm (.clock(clock), .rst_b(rst_b), .want(want),
      .pins(pins));
   frt_top uut (.clock(clock), .rst_b(rst_b), .standby(standby),
      .cap_in_a(pins[0]), .cap_in_b(pins[1]), .cap_in_c(pins[2]),
      .cap_in_d(pins[3]), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .cap_a_irq(irqs[6]), .cap_b_irq(irqs[5]),
      .cap_c_irq(irqs[4]), .cap_d_irq(irqs[3]), .cmp_a_irq(irqs[2]),
      .cmp_b_irq(irqs[1]), .wrap_irq(irqs[0]), .irq(irq));

   task automatic test_done;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done

   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr8(logic [15:0] a, logic [7:0] x);
      @(posedge clock);
      addr <= a;
      wdata <= x;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr8

   task automatic rd8(logic [15:0] a, output logic [15:0] q);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      q = {8'h00, rdata};
   endtask : rd8

   task automatic wr16(logic [15:0] a, logic [15:0] x);
      wr8(a, x[15:8]);
      wr8(a + 16'h0001, x[7:0]);
   endtask : wr16

   task automatic rd16(logic [15:0] a, output logic [15:0] q);
      logic [15:0] t;
      rd8(a, t);
      rd8(a + 16'h0001, q);
      q[15:8] = t[7:0];
   endtask : rd16

   task automatic settle(int n);
      repeat (n) @(posedge clock);
   endtask : settle

   task automatic wait_irq(int i, int lim);
      int n;
      for (n = 0; n < lim && irqs[i] !== 1'b1; n++) @(negedge clock);
      if (n == lim) begin
         miscompares++;
         $display("mismatch wait_irq expected 1 seen timeout");
         test_done();
      end
   endtask : wait_irq

   initial begin
      settle(20);
      rst_b <= 1'b1;
      rd8(`FRT_OFS_ENABLES, d);
      chk("enables_rst", d, 16'h0001);
      rd8(`FRT_OFS_STATUS, d);
      chk("status_rst", d, 16'h0000);
      rd8(16'hFF80, d);
      chk("unmapped", d, 16'h0000);
      wr8(`FRT_OFS_ENABLES, 8'h00);
      rd8(`FRT_OFS_ENABLES, d);
      chk("enables_bit0", d, 16'h0001);
      wr8(`FRT_OFS_STATUS, 8'hFF);
      rd8(`FRT_OFS_STATUS, d);
      chk("status_w1", d, 16'h0001);
      $display("test registers done");
      for (int i = 0; i < 2; i++) begin
         wr8(`FRT_OFS_STATUS, (i == 0) ? 8'h01 : 8'h00);
         wr8(`FRT_OFS_ENABLES, 8'h08 >> i);
         rd16(`FRT_OFS_COUNT_HI, v);
         wr16(`FRT_OFS_CMP_A_HI + 16'(2 * i), v + 16'h0100);
         wait_irq(2 - i, 400);
         rd8(`FRT_OFS_STATUS, d);
         chk("cmp_flag", 16'(d[3 - i]), 16'h0001);
         if (i == 0) begin
            rd16(`FRT_OFS_COUNT_HI, v);
            chk("count_cleared", 16'(v < 16'h0040), 16'h0001);
         end
         wr8(`FRT_OFS_STATUS, 8'h00);
         @(negedge clock);
         chk("cmp_irq_off", 16'(irqs[2 - i]), 16'h0000);
      end
      $display("test compare done");
      wr8(`FRT_OFS_ENABLES, 8'hF0);
      e = 8'($random(seed)) & 8'hF0;
      wr8(`FRT_OFS_CONTROL, e);
      for (int i = 0; i < 4; i++) begin
         want[i] <= ~e[7 - i];
         settle(8);
         rd8(`FRT_OFS_STATUS, d);
         chk("wrong_edge", 16'(d[7 - i]), 16'h0000);
         want[i] <= e[7 - i];
         settle(8);
         rd8(`FRT_OFS_STATUS, d);
         chk("cap_flag", 16'(d[7 - i]), 16'h0001);
         chk("cap_irq", 16'(irqs[6 - i]), 16'h0001);
         wr8(`FRT_OFS_STATUS, 8'h00);
         @(negedge clock);
         chk("cap_irq_off", 16'(irqs[6 - i]), 16'h0000);
      end
      wr8(`FRT_OFS_ENABLES, 8'h00);
      want[0] <= ~want[0];
      settle(8);
      want[0] <= ~want[0];
      settle(8);
      chk("cap_irq_masked", 16'(irqs[6]), 16'h0000);
      wr8(`FRT_OFS_STATUS, 8'h00);
      rd8(`FRT_OFS_STATUS, d);
      chk("no_read_no_clear", 16'(d[7]), 16'h0001);
      wr8(`FRT_OFS_STATUS, 8'h00);
      rd8(`FRT_OFS_STATUS, d);
      chk("read_then_clear", 16'(d[7]), 16'h0000);
      $display("test capture done");
      for (int p = 0; p < 2; p++) begin
         wr8(`FRT_OFS_CONTROL, 8'hA8 >> p);
         want[p] <= 1'b0;
         want[p + 2] <= 1'b0;
         settle(8);
         rd16(`FRT_OFS_CAP_A_HI + 16'(2 * p), old);
         want[p] <= 1'b1;
         settle(8);
         rd16(`FRT_OFS_CAP_C_HI + 16'(2 * p), v);
         chk("buf_shift", v, old);
         want[p + 2] <= 1'b1;
         settle(8);
         rd16(`FRT_OFS_CAP_C_HI + 16'(2 * p), d);
         chk("buf_kept", d, v);
         rd8(`FRT_OFS_STATUS, d);
         chk("ext_flag", 16'(d[5 - p]), 16'h0001);
         wr8(`FRT_OFS_STATUS, 8'h00);
      end
      $display("test buffer done");
      chk("irq_masked", 16'(irq), 16'h0000);
      wr8(`FRT_OFS_EVMASK, 8'hFE);
      @(negedge clock);
      chk("irq_unmasked", 16'(irq), 16'h0001);
      rd8(`FRT_OFS_EVENTS, d);
      wr8(`FRT_OFS_ENABLES, 8'h02);
      wait_irq(0, 70000);
      chk("irq_wrap", 16'(irq), 16'h0001);
      rd8(`FRT_OFS_STATUS, d);
      chk("wrap_flag", 16'(d[1]), 16'h0001);
      rd8(`FRT_OFS_EVENTS, d);
      chk("evt_wrap", 16'(d[1]), 16'h0001);
      chk("irq_cleared", 16'(irq), 16'h0000);
      $display("test wrap done");
      wr8(`FRT_OFS_ENABLES, 8'hFE);
      @(posedge clock);
      standby <= 1'b1;
      @(posedge clock);
      standby <= 1'b0;
      rd8(`FRT_OFS_ENABLES, d);
      chk("enables_stby", d, 16'h0001);
      rd8(`FRT_OFS_STATUS, d);
      chk("status_stby", d, 16'h0000);
      $display("test standby done");
      test_done();
   end
endmodule : tb_top
